// >>> core/boot_defs.svh
`ifndef BOOT_DEFS_SVH
`define BOOT_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL_ZERO 12'h000
`define OFS_CTRL_FOUR 12'h004
`define OFS_ACCUM 12'h008
`define OFS_DATA_D 12'h00c
`define OFS_COUNT 12'h010
`define OFS_GT_BASE 12'h014
`define OFS_GT_LIMIT 12'h018
`define OFS_GT_LOAD 12'h01c
`define OFS_IT_BASE 12'h020
`define OFS_IT_LIMIT 12'h024
`define OFS_IT_LOAD 12'h028
`define OFS_STATUS 12'h02c
`define OFS_FETCH 12'h030
`define OFS_NMI_DONE 12'h034
`define OFS_RANGE0 12'h040

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_PROT_ENABLE 0
`define BIT_OS_SIMD_SAVE 9
`define BIT_OS_SIMD_EXC 10
`define BIT_FQ_SIMD_A 25
`define BIT_FQ_SIMD_B 26
`define BIT_FQ_SAVE_RESTORE 24
`define BIT_FQ_LINE_FLUSH 19
`define BIT_FQ_SIMD_C 0
`define BIT_ST_PROT 0
`define BIT_ST_GT_READY 1
`define BIT_ST_IT_READY 2
`define BIT_ST_NMI_BUSY 3
`define BIT_RANGE_VALID 3
`define RANGE_TYPE_HI 2
`define RANGE_REGION_LO 8
`define RANGE_REGION_HI 15

// ----------------------------------------
// reset values and constants
// ----------------------------------------
`define RESET_FETCH_ADDR 32'hfffffff0
`define RESET_IT_BASE 32'h00000000
`define RESET_GT_BASE 32'h00000000
`define RESET_LIMIT 16'hffff
`define FEATURE_LEAF 32'h00000001
`define REAL_ADDR_TOP 32'h00100000
`define UNCACHED_TYPE 3'h0

`endif

// >>> core/boot_pkg.sv
package boot_pkg;

  // ----------------------------------------
  // operating modes
  // ----------------------------------------
  typedef enum logic [0:0] {
    mode_real = 1'b0,
    mode_prot = 1'b1
  } mode_t;

  // ----------------------------------------
  // apb access phases
  // ----------------------------------------
  typedef enum logic [1:0] {
    bus_idle = 2'b00,
    bus_setup = 2'b01,
    bus_access = 2'b10
  } bus_phase_t;

endpackage : boot_pkg

// >>> core/table_load_if.sv
interface table_load_if;
  logic load;
  logic [31:0] base;
  logic [15:0] limit;
  logic [31:0] base_q;
  logic [15:0] limit_q;
  logic loaded;

  modport ctrl (output load, output base, output limit,
                input base_q, input limit_q, input loaded);
  modport table_side (input load, input base, input limit,
                      output base_q, output limit_q, output loaded);
endinterface : table_load_if

// >>> core/table_reg.sv
`include "boot_defs.svh"

module table_reg #(
  parameter logic [31:0] RESET_BASE = 32'h00000000
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // load side
  table_load_if.table_side tl
);
  typedef struct packed {
    logic [31:0] base;
    logic [15:0] limit;
    logic loaded;
  } tbl_state_t;

  tbl_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (tl.load) begin
      // base and limit always move together
      s_d.base = tl.base;
      s_d.limit = tl.limit;
      s_d.loaded = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_q <= '{base: RESET_BASE, limit: `RESET_LIMIT, loaded: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign tl.base_q = s_q.base;
  assign tl.limit_q = s_q.limit;
  assign tl.loaded = s_q.loaded;
endmodule : table_reg

// >>> core/nmi_gate.sv
module nmi_gate (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // pin and service end
  input wire logic nmi_pin,
  input wire logic service_done,
  // status
  output logic take,
  output logic busy
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic busy;
    logic take;
  } nmi_state_t;

  nmi_state_t s_q, s_d;
  logic edge_seen;

  always_comb begin
    s_d = s_q;
    s_d.sync1 = nmi_pin;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    edge_seen = s_q.sync2 & ~s_q.prev;
    s_d.take = 1'b0;
    // an edge in the cycle service ends is still taken
    if (edge_seen && (!s_q.busy || service_done)) begin
      s_d.take = 1'b1;
      s_d.busy = 1'b1;
    end else if (service_done) begin
      s_d.busy = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign take = s_q.take;
  assign busy = s_q.busy;
endmodule : nmi_gate

// >>> core/cpu_boot_state.sv
// Functional notes
// - reset enters real mode, first fetch at fffffff0 below 4 GByte top.
// - real-mode vector table base resets to zero; table load replaces it.
// - real-mode handlers are reachable only inside the first megabyte.
// - all-zero range table entries select uncached; reset clears them.
// - feature flags: data bits 25,26,24,19 and count bit 0.
// - flags appear only when the query runs with accumulator equal one.
// - control four bit 9 holds the os simd save flag.
// - control four bit 10 holds the os simd exception flag.
// - nmi always accepted unless an earlier nmi is still serviced.
// - writing control zero bit 0 set switches to protected mode.
// - global table load takes base and limit; usable only afterwards.
// - interrupt table load takes base and limit; usable only afterwards.
`include "boot_defs.svh"

module cpu_boot_state
  import boot_pkg::*;
#(
  parameter int RANGE_N = 4,
  parameter bit HAS_SIMD_A = 1'b1,
  parameter bit HAS_SIMD_B = 1'b1,
  parameter bit HAS_SIMD_C = 1'b1,
  parameter bit HAS_SAVE_RESTORE = 1'b1,
  parameter bit HAS_LINE_FLUSH = 1'b1
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // non-maskable interrupt
  input wire logic nmi_pin,
  output logic nmi_take,
  output logic nmi_busy,
  // mode and fetch
  output logic real_mode,
  output logic [31:0] fetch_addr,
  // handler reach check
  input wire logic [31:0] handler_addr,
  output logic handler_ok,
  // memory type lookup
  input wire logic [31:0] access_addr,
  output logic [2:0] access_type,
  // simd enables
  output logic simd_save_en,
  output logic simd_exc_en,
  // descriptor tables
  output logic [31:0] gt_base,
  output logic [15:0] gt_limit,
  output logic gt_ready,
  output logic [31:0] it_base,
  output logic [15:0] it_limit,
  output logic it_ready
);

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  if (RANGE_N < 1 || RANGE_N > 8) begin : g_bad_range
    $error("RANGE_N must lie between 1 and 8");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    mode_t mode;
    logic [31:0] fetch;
    logic os_save;
    logic os_exc;
    logic [31:0] accum;
    logic [31:0] data_d;
    logic [31:0] count;
    logic [31:0] gt_base_stage;
    logic [15:0] gt_limit_stage;
    logic [31:0] it_base_stage;
    logic [15:0] it_limit_stage;
    logic [RANGE_N-1:0][15:0] ranges;
    logic [31:0] rdata;
    logic rd_err;
    logic [2:0] acc_type;
    logic hnd_ok;
  } boot_state_t;

  boot_state_t s_q, s_d;

  table_load_if gt_if ();
  table_load_if it_if ();

  logic wr_en;
  logic setup;
  logic nmi_done;
  logic [31:0] rd_val;
  logic rd_hit;
  logic [2:0] look_type;
  logic [31:0] status;
  logic [31:0] ctrl_zero;
  logic [31:0] ctrl_four;
  logic [31:0] flags_d;
  logic [31:0] flags_c;

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign nmi_done = wr_en && (paddr == `OFS_NMI_DONE);

  // ----------------------------------------
  // feature flags
  // ----------------------------------------
  always_comb begin
    flags_d = 32'h00000000;
    flags_c = 32'h00000000;
    flags_d[`BIT_FQ_SIMD_A] = HAS_SIMD_A;
    flags_d[`BIT_FQ_SIMD_B] = HAS_SIMD_B;
    flags_d[`BIT_FQ_SAVE_RESTORE] = HAS_SAVE_RESTORE;
    flags_d[`BIT_FQ_LINE_FLUSH] = HAS_LINE_FLUSH;
    flags_c[`BIT_FQ_SIMD_C] = HAS_SIMD_C;
  end

  // ----------------------------------------
  // register views
  // ----------------------------------------
  always_comb begin
    ctrl_zero = 32'h00000000;
    ctrl_zero[`BIT_PROT_ENABLE] = (s_q.mode == mode_prot);
    ctrl_four = 32'h00000000;
    ctrl_four[`BIT_OS_SIMD_SAVE] = s_q.os_save;
    ctrl_four[`BIT_OS_SIMD_EXC] = s_q.os_exc;
    status = 32'h00000000;
    status[`BIT_ST_PROT] = (s_q.mode == mode_prot);
    status[`BIT_ST_GT_READY] = gt_if.loaded;
    status[`BIT_ST_IT_READY] = it_if.loaded;
    status[`BIT_ST_NMI_BUSY] = nmi_busy;
  end

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  always_comb begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    if (paddr == `OFS_CTRL_ZERO) begin
      rd_val = ctrl_zero;
    end else if (paddr == `OFS_CTRL_FOUR) begin
      rd_val = ctrl_four;
    end else if (paddr == `OFS_ACCUM) begin
      rd_val = s_q.accum;
    end else if (paddr == `OFS_DATA_D) begin
      rd_val = s_q.data_d;
    end else if (paddr == `OFS_COUNT) begin
      rd_val = s_q.count;
    end else if (paddr == `OFS_GT_BASE) begin
      rd_val = gt_if.base_q;
    end else if (paddr == `OFS_GT_LIMIT) begin
      rd_val = {16'h0000, gt_if.limit_q};
    end else if (paddr == `OFS_IT_BASE) begin
      rd_val = it_if.base_q;
    end else if (paddr == `OFS_IT_LIMIT) begin
      rd_val = {16'h0000, it_if.limit_q};
    end else if (paddr == `OFS_STATUS) begin
      rd_val = status;
    end else if (paddr == `OFS_FETCH) begin
      rd_val = s_q.fetch;
    end else if (paddr == `OFS_GT_LOAD || paddr == `OFS_IT_LOAD || paddr == `OFS_NMI_DONE) begin
      rd_val = 32'h00000000;
    end else if (paddr >= `OFS_RANGE0 &&
                 paddr < `OFS_RANGE0 + 12'(4 * RANGE_N) && paddr[1:0] == 2'b00) begin
      rd_val = {16'h0000, s_q.ranges[paddr[4:2]]};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ----------------------------------------
  // memory type lookup
  // ----------------------------------------
  // first valid matching entry wins; an unused entry never matches
  always_comb begin
    look_type = `UNCACHED_TYPE;
    for (int i = RANGE_N - 1; i >= 0; i--) begin
      if (s_q.ranges[i][`BIT_RANGE_VALID] &&
          s_q.ranges[i][`RANGE_REGION_HI:`RANGE_REGION_LO] == access_addr[31:24]) begin
        look_type = s_q.ranges[i][`RANGE_TYPE_HI:0];
      end
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    gt_if.load = 1'b0;
    gt_if.base = s_q.gt_base_stage;
    gt_if.limit = s_q.gt_limit_stage;
    it_if.load = 1'b0;
    it_if.base = s_q.it_base_stage;
    it_if.limit = s_q.it_limit_stage;
    s_d.acc_type = look_type;
    // the megabyte limit applies only while in real mode
    s_d.hnd_ok = (s_q.mode == mode_prot) || (handler_addr < `REAL_ADDR_TOP);
    // read data is caught in setup so the answer comes from a flop
    if (setup) begin
      s_d.rdata = pwrite ? 32'h00000000 : rd_val;
      s_d.rd_err = ~rd_hit;
    end
    if (wr_en && rd_hit) begin
      if (paddr == `OFS_CTRL_ZERO) begin
        // clearing the flag drops back to real mode
        s_d.mode = pwdata[`BIT_PROT_ENABLE] ? mode_prot : mode_real;
      end else if (paddr == `OFS_CTRL_FOUR) begin
        s_d.os_save = pwdata[`BIT_OS_SIMD_SAVE];
        s_d.os_exc = pwdata[`BIT_OS_SIMD_EXC];
      end else if (paddr == `OFS_ACCUM) begin
        // writing the accumulator runs the query
        s_d.accum = pwdata;
        if (pwdata == `FEATURE_LEAF) begin
          s_d.data_d = flags_d;
          s_d.count = flags_c;
        end else begin
          s_d.data_d = 32'h00000000;
          s_d.count = 32'h00000000;
        end
      end else if (paddr == `OFS_GT_BASE) begin
        s_d.gt_base_stage = pwdata;
      end else if (paddr == `OFS_GT_LIMIT) begin
        s_d.gt_limit_stage = pwdata[15:0];
      end else if (paddr == `OFS_GT_LOAD) begin
        gt_if.load = 1'b1;
      end else if (paddr == `OFS_IT_BASE) begin
        s_d.it_base_stage = pwdata;
      end else if (paddr == `OFS_IT_LIMIT) begin
        s_d.it_limit_stage = pwdata[15:0];
      end else if (paddr == `OFS_IT_LOAD) begin
        it_if.load = 1'b1;
      end else if (paddr >= `OFS_RANGE0) begin
        s_d.ranges[paddr[4:2]] = pwdata[15:0];
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_q.mode <= mode_real;
      s_q.fetch <= `RESET_FETCH_ADDR;
      s_q.os_save <= 1'b0;
      s_q.os_exc <= 1'b0;
      s_q.accum <= 32'h00000000;
      s_q.data_d <= 32'h00000000;
      s_q.count <= 32'h00000000;
      s_q.gt_base_stage <= 32'h00000000;
      s_q.gt_limit_stage <= 16'h0000;
      s_q.it_base_stage <= 32'h00000000;
      s_q.it_limit_stage <= 16'h0000;
      s_q.ranges <= '0;
      s_q.rdata <= 32'h00000000;
      s_q.rd_err <= 1'b0;
      s_q.acc_type <= `UNCACHED_TYPE;
      s_q.hnd_ok <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // sub-blocks
  // ----------------------------------------
  table_reg #(
    .RESET_BASE(`RESET_GT_BASE)
  ) u_global_table (
    .clock(clock),
    .reset(reset),
    .tl(gt_if.table_side)
  );

  table_reg #(
    .RESET_BASE(`RESET_IT_BASE)
  ) u_interrupt_table (
    .clock(clock),
    .reset(reset),
    .tl(it_if.table_side)
  );

  nmi_gate u_nmi (
    .clock(clock),
    .reset(reset),
    .nmi_pin(nmi_pin),
    .service_done(nmi_done),
    .take(nmi_take),
    .busy(nmi_busy)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // zero wait states: the access phase always completes at once
  assign pready = psel & penable;
  assign pslverr = psel & penable & s_q.rd_err;
  assign prdata = s_q.rdata;
  assign real_mode = (s_q.mode == mode_real);
  assign fetch_addr = s_q.fetch;
  assign handler_ok = s_q.hnd_ok;
  assign access_type = s_q.acc_type;
  assign simd_save_en = s_q.os_save;
  assign simd_exc_en = s_q.os_exc;
  assign gt_base = gt_if.base_q;
  assign gt_limit = gt_if.limit_q;
  assign gt_ready = gt_if.loaded;
  assign it_base = it_if.base_q;
  assign it_limit = it_if.limit_q;
  assign it_ready = it_if.loaded;

endmodule : cpu_boot_state

// >>> verif/boot_state_checker.sv
`include "boot_defs.svh"

module boot_state_checker (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // mode and reach
  input wire logic real_mode,
  input wire logic [31:0] fetch_addr,
  input wire logic [31:0] handler_addr,
  input wire logic handler_ok,
  input wire logic [2:0] access_type,
  // flags and tables
  input wire logic simd_save_en,
  input wire logic simd_exc_en,
  input wire logic [31:0] it_base,
  input wire logic gt_ready,
  input wire logic it_ready,
  // nmi
  input wire logic nmi_take,
  input wire logic nmi_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic range_written_q;
  wire logic wr_acc = psel && penable && pwrite;

  // one sticky bit, cheaper than mirroring every range entry
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      range_written_q <= 1'b0;
    end else if (wr_acc && paddr >= `OFS_RANGE0) begin
      range_written_q <= 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  reset_state_a: assert property ($fell(reset) |-> real_mode && fetch_addr == 32'hfffffff0
    && it_base == 32'h0 && !simd_save_en && !simd_exc_en) else $error("bad state after reset");
  handler_reach_a: assert property (!$past(reset) |-> handler_ok ==
    (!$past(real_mode) || $past(handler_addr) < 32'h00100000)) else $error("handler reach wrong");
  uncached_a: assert property (!range_written_q |-> access_type == 3'h0)
    else $error("cleared ranges not uncached");
  simd_save_a: assert property (wr_acc && paddr == `OFS_CTRL_FOUR |=>
    simd_save_en == $past(pwdata[9])) else $error("save flag not taken");
  simd_exc_a: assert property (wr_acc && paddr == `OFS_CTRL_FOUR |=>
    simd_exc_en == $past(pwdata[10])) else $error("exception flag not taken");
  prot_switch_a: assert property (wr_acc && paddr == `OFS_CTRL_ZERO |=>
    real_mode == !$past(pwdata[0])) else $error("mode switch wrong");
  gt_load_a: assert property (wr_acc && paddr == `OFS_GT_LOAD |=> gt_ready)
    else $error("global table not ready");
  gt_gate_a: assert property ($rose(gt_ready) |-> $past(wr_acc && paddr == `OFS_GT_LOAD))
    else $error("global table ready without load");
  it_load_a: assert property (wr_acc && paddr == `OFS_IT_LOAD |=> it_ready)
    else $error("interrupt table not ready");
  nmi_take_a: assert property (nmi_take |-> nmi_busy ##1 !nmi_take)
    else $error("nmi take not a busy pulse");
  nmi_done_a: assert property (wr_acc && paddr == `OFS_NMI_DONE |=> !nmi_busy || nmi_take)
    else $error("nmi service not ended");

  take_c: cover property (nmi_take);
  prot_c: cover property (wr_acc && paddr == `OFS_CTRL_ZERO && pwdata[0]);
  type_c: cover property (access_type != 3'h0);
endmodule : boot_state_checker

bind cpu_boot_state boot_state_checker chk_u (
  .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .real_mode(real_mode), .fetch_addr(fetch_addr),
  .handler_addr(handler_addr), .handler_ok(handler_ok), .access_type(access_type),
  .simd_save_en(simd_save_en), .simd_exc_en(simd_exc_en), .it_base(it_base),
  .gt_ready(gt_ready), .it_ready(it_ready), .nmi_take(nmi_take), .nmi_busy(nmi_busy));

// >>> verif/cpu_boot_mode_init_state_test.sv
`include "boot_defs.svh"

module cpu_boot_mode_init_state_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, nmi_pin = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, handler_addr = 32'h0, access_addr = 32'h0, rd;
  logic [31:0] prdata, fetch_addr, gt_base, it_base;
  logic [15:0] gt_limit, it_limit;
  logic [2:0] access_type;
  logic pready, pslverr, nmi_take, nmi_busy, real_mode, handler_ok, err;
  logic simd_save_en, simd_exc_en, gt_ready, it_ready;
  int bad_count = 0, total_checks = 0, cycles = 0;

  cpu_boot_state dut_u (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nmi_pin(nmi_pin), .nmi_take(nmi_take), .nmi_busy(nmi_busy),
    .real_mode(real_mode), .fetch_addr(fetch_addr), .handler_addr(handler_addr),
    .handler_ok(handler_ok), .access_addr(access_addr), .access_type(access_type),
    .simd_save_en(simd_save_en), .simd_exc_en(simd_exc_en), .gt_base(gt_base),
    .gt_limit(gt_limit), .gt_ready(gt_ready), .it_base(it_base), .it_limit(it_limit),
    .it_ready(it_ready));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // entered just after an edge; leaves one idle edge so psel never toggles twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic pulse(output logic got);
    nmi_pin <= 1'b1;
    @(posedge clock);
    nmi_pin <= 1'b0;
    got = 1'b0;
    repeat (8) begin
      @(posedge clock);
      got |= (nmi_take === 1'b1);
    end
  endtask : pulse

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check(real_mode, 1);
    check(fetch_addr, 32'hfffffff0);
    check(it_base, 0);
    check({simd_exc_en, simd_save_en}, 0);
    apb(0, `OFS_CTRL_FOUR, 0);
    check(rd[10:9], 0);
    apb(0, `OFS_FETCH, 0);
    check(rd, 32'hfffffff0);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_feature();
    for (int v = 0; v < 3; v++) begin
      apb(1, `OFS_ACCUM, 32'(v));
      apb(0, `OFS_DATA_D, 0);
      check(rd, (v == 1) ? 32'h07080000 : 32'h0);
      apb(0, `OFS_COUNT, 0);
      check(rd, 32'(v == 1));
    end
    $display("t_feature done");
  endtask : t_feature

  task automatic t_simd();
    for (int v = 0; v < 4; v++) begin
      apb(1, `OFS_CTRL_FOUR, 32'(v << 9));
      check({simd_exc_en, simd_save_en}, 32'(v));
      apb(0, `OFS_CTRL_FOUR, 0);
      check(rd[10:9], 32'(v));
    end
    $display("t_simd done");
  endtask : t_simd

  // base and limit staged first: nothing may show before the load write
  task automatic t_tables();
    logic [11:0] o;
    for (int i = 0; i < 2; i++) begin
      o = (i == 1) ? `OFS_IT_BASE : `OFS_GT_BASE;
      apb(1, o, 32'h00123400 + 32'(i));
      apb(1, o + 12'h004, 32'h000003ff);
      check((i == 1) ? it_ready : gt_ready, 0);
      check((i == 1) ? it_base : gt_base, 0);
      apb(1, o + 12'h008, 0);
      check((i == 1) ? it_base : gt_base, 32'h00123400 + 32'(i));
      check((i == 1) ? {it_ready, it_limit} : {gt_ready, gt_limit}, 32'h103ff);
      apb(0, o, 0);
      check(rd, 32'h00123400 + 32'(i));
      apb(0, o + 12'h004, 0);
      check(rd, 32'h000003ff);
    end
    apb(0, `OFS_STATUS, 0);
    check(rd[2:1], 2'b11);
    $display("t_tables done");
  endtask : t_tables

  task automatic t_ranges();
    access_addr <= 32'h80000000;
    repeat (2) @(posedge clock);
    check(access_type, 0);
    apb(1, `OFS_RANGE0, 32'h0000800e);
    apb(0, `OFS_RANGE0, 0);
    check(rd, 32'h0000800e);
    check(access_type, 6);
    apb(1, `OFS_RANGE0, 0);
    repeat (2) @(posedge clock);
    check(access_type, 0);
    apb(0, 12'h3fc, 0);
    check(err, 1);
    check(rd, 0);
    $display("t_ranges done");
  endtask : t_ranges

  task automatic t_mode();
    handler_addr <= 32'h000ffffc;
    repeat (2) @(posedge clock);
    check(handler_ok, 1);
    handler_addr <= 32'h00100000;
    repeat (2) @(posedge clock);
    check(handler_ok, 0);
    apb(1, `OFS_CTRL_ZERO, 1);
    check(real_mode, 0);
    @(posedge clock);
    check(handler_ok, 1);
    apb(0, `OFS_STATUS, 0);
    check(rd[0], 1);
    apb(1, `OFS_CTRL_ZERO, 0);
    check(real_mode, 1);
    $display("t_mode done");
  endtask : t_mode

  task automatic t_nmi();
    logic got;
    pulse(got);
    check({got, nmi_busy}, 2'b11);
    pulse(got);
    check({got, nmi_busy}, 2'b01);
    apb(1, `OFS_NMI_DONE, 0);
    check(nmi_busy, 0);
    pulse(got);
    check(got, 1);
    apb(1, `OFS_NMI_DONE, 0);
    $display("t_nmi done");
  endtask : t_nmi

  // mid-run reset after protection and simd flags were set
  task automatic t_rereset();
    apb(1, `OFS_CTRL_FOUR, 32'h00000600);
    apb(1, `OFS_CTRL_ZERO, 1);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    check(real_mode, 1);
    check(fetch_addr, 32'hfffffff0);
    check({simd_exc_en, simd_save_en}, 0);
    check(it_base, 0);
    check(it_ready, 0);
    $display("t_rereset done");
  endtask : t_rereset

  // ----------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    forever #10 clock = ~clock;
  end

  // whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_reset();
    t_feature();
    t_simd();
    t_tables();
    t_ranges();
    t_mode();
    t_nmi();
    t_rereset();
    tally_and_finish();
  end
endmodule : cpu_boot_mode_init_state_test
